// >>> rtl/mpc_pin_ctrl.sv
// Operation
// R1 - low address bits come from two straps, first strap is the lower bit
// R2 - in tree test mode the low strap pin drives the tree result
// R3 - serial data is open drain only, pull low or release, also sampled
// R4 - high level on case sense line means intrusion
// R5 - case line pulled low at least 20 ms by config bit 6 or clear bit 7
// R6 - interrupt output enabled only while config bit 1 is set, off after reset
// R7 - tree test mode while test select input is high
// R8 - without tree mode the shared pin is the analog output
// R9 - reset pin driven low open drain for at least 20 ms
// R10 - reset pulse only when enabled by control bit 7, started by config bit 4
// R11 - external low on reset pin is a reset request
// R12 - external reset returns all registers to defaults
// R13 - a counter times each pulse, releases the line and clears its trigger
// R14 - own reset pulse is not taken as an external reset
`timescale 1ns/10ps
`default_nettype none
module mpc_pin_ctrl
   import mpc_pkg::*;
#(
   parameter int PULSE_LEN = PULSE_CYCLES
)(
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   input  wire logic        LINK_CLK,
   input  wire logic        SDA_I,
   output var  logic        SDA_O,
   output var  logic        SDA_OE,
   input  wire logic        ADDR_LOW_STRAP_TREE_OUT_I,
   output var  logic        ADDR_LOW_STRAP_TREE_OUT_O,
   output var  logic        ADDR_LOW_STRAP_TREE_OUT_OE,
   input  wire logic        ADDR_HIGH_STRAP,
   input  wire logic        CASE_OPEN_SENSE_I,
   output var  logic        CASE_OPEN_SENSE_O,
   output var  logic        CASE_OPEN_SENSE_OE,
   input  wire logic        TREE_TEST_SEL_DAC_OUT,
   output var  logic [7:0]  DAC_CODE,
   output var  logic        DAC_EN,
   input  wire logic        IRQ_REQ,
   output var  logic        INT_B_O,
   output var  logic        INT_B_OE,
   input  wire logic        RESET_PIN_I,
   output var  logic        RESET_PIN_O,
   output var  logic        RESET_PIN_OE,
   output var  logic [1:0]  SLAVE_ADDR_LOW
);
   logic [7:0]        cfg;
   logic [7:0]        rst_ctrl;
   logic [7:0]        case_clr;
   logic [7:0]        link_ctrl;
   logic [7:0]        last_byte;
   logic [TREE_W-1:0] pin_s1;
   logic [TREE_W-1:0] pin_s2;
   logic              tsel_s1;
   logic              tsel_s2;
   logic              rpin_s1;
   logic              rpin_s2;
   logic              tog_s1;
   logic              tog_s2;
   logic              tog_s3;
   logic              strap_done;
   logic [2:0]        holdoff;
   logic              ext_rst;
   logic              core_rst;
   logic              tree_mode;
   logic [TREE_W-1:0] chain;
   logic [7:0]        idx;
   logic              wr_en;
   logic              rd_ok;
   logic [31:0]       next_rdata;
   logic [31:0]       status;

   mpc_pulse_if rst_pls ();
   mpc_pulse_if case_pls ();
   mpc_link_if  lnk ();

   // ****************************************
   // input synchronisers
   // ****************************************
   always_ff @(posedge CLK) begin
      pin_s1  <= {RESET_PIN_I, SDA_I, CASE_OPEN_SENSE_I, ADDR_HIGH_STRAP,
                  ADDR_LOW_STRAP_TREE_OUT_I};
      pin_s2  <= pin_s1;
      tsel_s1 <= TREE_TEST_SEL_DAC_OUT;
      tsel_s2 <= tsel_s1;
      rpin_s1 <= RESET_PIN_I;
      rpin_s2 <= rpin_s1;
      tog_s1  <= lnk.rx_toggle;
      tog_s2  <= tog_s1;
      tog_s3  <= tog_s2;
   end

   // ****************************************
   // reset combining
   // ****************************************
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         holdoff <= '0;
      end else if (rst_pls.active) begin
         holdoff <= 3'(HOLDOFF); // R14
      end else if (holdoff != '0) begin
         holdoff <= holdoff - 1'b1;
      end
   end

   assign ext_rst   = !rpin_s2 && !rst_pls.active && (holdoff == '0); // R11 R14
   assign core_rst  = !RST_B || ext_rst; // R12
   assign tree_mode = tsel_s2; // R7

   // ****************************************
   // apb decode
   // ****************************************
   assign idx   = PADDR[9:2];
   assign wr_en = PSEL && PENABLE && PREADY && PWRITE;

   always_comb begin
      status                            = '0;
      status[ST_CASE]                   = pin_s2[2]; // R4
      status[ST_STRAP_LO +: 2]          = SLAVE_ADDR_LOW;
      status[ST_TREE]                   = tree_mode;
      status[ST_RST_ACT]                = rst_pls.active;
      status[ST_CASE_ACT]               = case_pls.active;
      status[ST_IRQ]                    = IRQ_REQ;
      status[ST_BYTE_LO +: 8]           = last_byte;
   end

   always_comb begin
      next_rdata = '0;
      rd_ok      = 1'b1;
      if (PADDR[1:0] != 2'h0 || PADDR[11:10] != 2'h0) begin
         rd_ok = 1'b0;
      end else if (idx == IDX_CONFIG) begin
         next_rdata[7:0] = cfg;
      end else if (idx == IDX_RST_CTRL) begin
         next_rdata[7:0] = rst_ctrl;
      end else if (idx == IDX_CASE_CLR) begin
         next_rdata[7:0] = case_clr;
      end else if (idx == IDX_DAC) begin
         next_rdata[7:0] = DAC_CODE;
      end else if (idx == IDX_STATUS) begin
         next_rdata = status;
      end else if (idx == IDX_LINK) begin
         next_rdata[7:0] = link_ctrl;
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         PREADY  <= 1'b0;
         PRDATA  <= '0;
         PSLVERR <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         PREADY  <= 1'b1;
         PRDATA  <= PWRITE ? 32'h0000_0000 : next_rdata;
         PSLVERR <= !rd_ok;
      end else begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end
   end

   // ****************************************
   // configuration and trigger bits
   // ****************************************
   always_ff @(posedge CLK) begin
      if (core_rst) begin
         cfg <= CFG_RST; // R12
      end else if (wr_en && rd_ok && idx == IDX_CONFIG) begin
         cfg             <= PWDATA[7:0];
         cfg[CFG_RST_GO] <= PWDATA[CFG_RST_GO] && rst_ctrl[RSTC_EN]; // R10
      end else begin
         if (rst_pls.done) begin
            cfg[CFG_RST_GO] <= 1'b0; // R13
         end
         if (case_pls.done) begin
            cfg[CFG_CASE_GO] <= 1'b0; // R13
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (core_rst) begin
         rst_ctrl <= RSTC_RST;
      end else if (wr_en && rd_ok && idx == IDX_RST_CTRL) begin
         rst_ctrl <= PWDATA[7:0]; // R10
      end
   end

   always_ff @(posedge CLK) begin
      if (core_rst) begin
         case_clr <= CASE_RST;
      end else if (wr_en && rd_ok && idx == IDX_CASE_CLR) begin
         case_clr <= PWDATA[7:0];
      end else if (case_pls.done) begin
         case_clr[CASE_GO] <= 1'b0; // R13
      end
   end

   always_ff @(posedge CLK) begin
      if (core_rst) begin
         DAC_CODE  <= DAC_RST;
         link_ctrl <= '0;
      end else if (wr_en && rd_ok && idx == IDX_DAC) begin
         DAC_CODE <= PWDATA[7:0];
      end else if (wr_en && rd_ok && idx == IDX_LINK) begin
         link_ctrl <= PWDATA[7:0];
      end
   end

   assign lnk.pull = link_ctrl[LINK_PULL]; // R3

   always_ff @(posedge CLK) begin
      if (core_rst) begin
         last_byte <= '0;
      end else if (tog_s2 != tog_s3) begin
         last_byte <= lnk.rx_byte;
      end
   end

   // ****************************************
   // timed pulses
   // ****************************************
   assign rst_pls.start  = cfg[CFG_RST_GO] && rst_ctrl[RSTC_EN]; // R10
   assign case_pls.start = cfg[CFG_CASE_GO] || case_clr[CASE_GO]; // R5

   mpc_pulse_timer #(.CYCLES(PULSE_LEN)) u_rst_timer (
      .clk (CLK),
      .rst (!RST_B),
      .pls (rst_pls)
   );

   mpc_pulse_timer #(.CYCLES(PULSE_LEN)) u_case_timer (
      .clk (CLK),
      .rst (core_rst),
      .pls (case_pls)
   );

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         RESET_PIN_O  <= 1'b0;
         RESET_PIN_OE <= 1'b0;
      end else begin
         RESET_PIN_O  <= 1'b0;           // R9
         RESET_PIN_OE <= rst_pls.active; // R9
      end
   end

   always_ff @(posedge CLK) begin
      if (core_rst) begin
         CASE_OPEN_SENSE_O  <= 1'b0;
         CASE_OPEN_SENSE_OE <= 1'b0;
      end else begin
         CASE_OPEN_SENSE_O  <= 1'b0;            // R5
         CASE_OPEN_SENSE_OE <= case_pls.active; // R5
      end
   end

   // ****************************************
   // interrupt output gate
   // ****************************************
   always_ff @(posedge CLK) begin
      if (core_rst) begin
         INT_B_O  <= 1'b0;
         INT_B_OE <= 1'b0; // R6
      end else begin
         INT_B_O  <= 1'b0;
         INT_B_OE <= cfg[CFG_INT_EN] && IRQ_REQ; // R6
      end
   end

   // ****************************************
   // address straps
   // ****************************************
   always_ff @(posedge CLK) begin
      if (core_rst) begin
         SLAVE_ADDR_LOW <= STRAP_RST;
         strap_done     <= 1'b0;
      end else if (!strap_done && !tree_mode) begin
         SLAVE_ADDR_LOW <= {pin_s2[1], pin_s2[0]}; // R1
         strap_done     <= 1'b1;
      end
   end

   // ****************************************
   // nand tree and shared analog pin
   // ****************************************
   assign chain[0] = pin_s2[1];
   generate
      for (genvar i = 1; i < TREE_W; i++) begin : g_tree
         assign chain[i] = ~(chain[i-1] & pin_s2[i]);
      end
   endgenerate

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         ADDR_LOW_STRAP_TREE_OUT_O  <= 1'b0;
         ADDR_LOW_STRAP_TREE_OUT_OE <= 1'b0;
         DAC_EN                     <= 1'b0;
      end else begin
         ADDR_LOW_STRAP_TREE_OUT_O  <= chain[TREE_W-1]; // R2
         ADDR_LOW_STRAP_TREE_OUT_OE <= tree_mode;        // R2
         DAC_EN                     <= !tree_mode;       // R8
      end
   end

   mpc_link u_link (
      .link_clk (LINK_CLK),
      .rst_b    (RST_B),
      .sda_i    (SDA_I),
      .sda_o    (SDA_O),
      .sda_oe   (SDA_OE),
      .lnk      (lnk)
   );
endmodule : mpc_pin_ctrl
`default_nettype wire

// >>> rtl/mpc_pkg.sv
`default_nettype none
package mpc_pkg;
   // ****************************************
   // register indices, byte address = 4 * index
   // ****************************************
   localparam logic [7:0] IDX_CONFIG   = 8'h40;
   localparam logic [7:0] IDX_RST_CTRL = 8'h44;
   localparam logic [7:0] IDX_CASE_CLR = 8'h46;
   localparam logic [7:0] IDX_DAC      = 8'h48;
   localparam logic [7:0] IDX_STATUS   = 8'h4a;
   localparam logic [7:0] IDX_LINK     = 8'h4c;
   // ****************************************
   // field positions
   // ****************************************
   localparam int CFG_INT_EN   = 1;
   localparam int CFG_RST_GO   = 4;
   localparam int CFG_CASE_GO  = 6;
   localparam int RSTC_EN      = 7;
   localparam int CASE_GO      = 7;
   localparam int LINK_PULL    = 0;
   localparam int ST_CASE      = 0;
   localparam int ST_STRAP_LO  = 1;
   localparam int ST_TREE      = 3;
   localparam int ST_RST_ACT   = 4;
   localparam int ST_CASE_ACT  = 5;
   localparam int ST_IRQ       = 6;
   localparam int ST_BYTE_LO   = 8;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] CFG_RST      = 8'h00;
   localparam logic [7:0] RSTC_RST     = 8'h00;
   localparam logic [7:0] CASE_RST     = 8'h00;
   localparam logic [7:0] DAC_RST      = 8'h00;
   localparam logic [1:0] STRAP_RST    = 2'h0;
   // ****************************************
   // timing
   // ****************************************
   localparam int PULSE_MS     = 20;
   localparam int CLK_MHZ      = 100;
   localparam int PULSE_CYCLES = PULSE_MS * 1000 * CLK_MHZ;
   localparam int HOLDOFF      = 4;
   localparam int TREE_W       = 5;
endpackage : mpc_pkg
`default_nettype wire

// >>> rtl/mpc_if.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// timed open-drain pulse handshake
// ****************************************
interface mpc_pulse_if;
   logic start;
   logic active;
   logic done;
   modport owner (output start, input active, input done);
   modport timer (input start, output active, output done);
endinterface : mpc_pulse_if

// ****************************************
// core to link domain signals
// ****************************************
interface mpc_link_if;
   logic       pull;
   logic [7:0] rx_byte;
   logic       rx_toggle;
   modport core (output pull, input rx_byte, input rx_toggle);
   modport link (input pull, output rx_byte, output rx_toggle);
endinterface : mpc_link_if
`default_nettype wire

// >>> rtl/mpc_pulse_timer.sv
`timescale 1ns/10ps
`default_nettype none
module mpc_pulse_timer
   import mpc_pkg::*;
#(
   parameter int CYCLES = PULSE_CYCLES
)(
   input wire logic   clk,
   input wire logic   rst,
   mpc_pulse_if.timer pls
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

   logic [CW-1:0] cnt;

   // ****************************************
   // pulse counter
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         pls.active <= 1'b0;
         cnt        <= '0;
      end else if (!pls.active) begin
         if (pls.start) begin
            pls.active <= 1'b1;
            cnt        <= LOAD;
         end
      end else if (cnt == '0) begin
         pls.active <= 1'b0; // R13
      end else begin
         cnt <= cnt - 1'b1;
      end
   end

   assign pls.done = pls.active && (cnt == '0); // R13
endmodule : mpc_pulse_timer
`default_nettype wire

// >>> rtl/mpc_link.sv
`timescale 1ns/10ps
`default_nettype none
module mpc_link
   import mpc_pkg::*;
(
   input  wire logic link_clk,
   input  wire logic rst_b,
   input  wire logic sda_i,
   output var  logic sda_o,
   output var  logic sda_oe,
   mpc_link_if.link  lnk
);
   logic       rst_s1;
   logic       rst_s2;
   logic       sda_s1;
   logic       sda_s2;
   logic       pull_s1;
   logic       pull_s2;
   logic [6:0] shift;
   logic [2:0] bit_cnt;

   // ****************************************
   // synchronisers in link domain
   // ****************************************
   always_ff @(posedge link_clk) begin
      rst_s1  <= rst_b;
      rst_s2  <= rst_s1;
      sda_s1  <= sda_i;
      sda_s2  <= sda_s1;
      pull_s1 <= lnk.pull;
      pull_s2 <= pull_s1;
   end

   // ****************************************
   // open-drain data drive
   // ****************************************
   always_ff @(posedge link_clk) begin
      if (!rst_s2) begin
         sda_o  <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         sda_o  <= 1'b0;    // R3
         sda_oe <= pull_s2; // R3
      end
   end

   // ****************************************
   // byte capture
   // ****************************************
   always_ff @(posedge link_clk) begin
      if (!rst_s2) begin
         shift         <= '0;
         bit_cnt       <= '0;
         lnk.rx_byte   <= '0;
         lnk.rx_toggle <= 1'b0;
      end else begin
         shift   <= {shift[5:0], sda_s2}; // R3
         bit_cnt <= bit_cnt + 1'b1;
         if (bit_cnt == 3'h7) begin
            lnk.rx_byte   <= {shift, sda_s2};
            lnk.rx_toggle <= ~lnk.rx_toggle;
         end
      end
   end
endmodule : mpc_link
`default_nettype wire

// >>> test/mpc_pin_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module mpc_pin_ctrl_chk
   import mpc_pkg::*;
#(
   parameter int PULSE_LEN = PULSE_CYCLES
)(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic IRQ_REQ,
   input wire logic INT_B_O,
   input wire logic INT_B_OE,
   input wire logic SDA_O,
   input wire logic RESET_PIN_O,
   input wire logic RESET_PIN_OE,
   input wire logic CASE_OPEN_SENSE_O,
   input wire logic CASE_OPEN_SENSE_OE,
   input wire logic TREE_TEST_SEL_DAC_OUT,
   input wire logic ADDR_LOW_STRAP_TREE_OUT_OE,
   input wire logic DAC_EN
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   int rst_n;
   int case_n;
   // ****************************************
   // pulse high-time counters
   // ****************************************
   always_ff @(posedge CLK) begin
      rst_n <= RESET_PIN_OE ? rst_n + 1 : 0;
   end
   always_ff @(posedge CLK) begin
      case_n <= CASE_OPEN_SENSE_OE ? case_n + 1 : 0;
   end
   ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready after setup");
   ready_single_a: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   err_with_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   od_low_only_a: assert property (!(SDA_O || INT_B_O || RESET_PIN_O || CASE_OPEN_SENSE_O))
      else $error("open drain pin driven high");
   irq_gate_a: assert property (INT_B_OE |-> $past(IRQ_REQ))
      else $error("interrupt without request");
   rst_pulse_len_a: assert property ($fell(RESET_PIN_OE) |-> rst_n == PULSE_LEN)
      else $error("reset pulse length wrong");
   case_pulse_len_a: assert property ($fell(CASE_OPEN_SENSE_OE) |-> case_n == PULSE_LEN)
      else $error("case clear pulse length wrong");
   tree_dac_excl_a: assert property ($past(RST_B) |-> DAC_EN != ADDR_LOW_STRAP_TREE_OUT_OE)
      else $error("tree output and dac both or neither");
   tree_enter_a: assert property ($rose(TREE_TEST_SEL_DAC_OUT) |-> ##[1:4] ADDR_LOW_STRAP_TREE_OUT_OE)
      else $error("tree mode not entered");
endmodule : mpc_pin_ctrl_chk
bind mpc_pin_ctrl mpc_pin_ctrl_chk #(.PULSE_LEN(PULSE_LEN)) i_mpc_pin_ctrl_chk (
   .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .IRQ_REQ(IRQ_REQ), .INT_B_O(INT_B_O), .INT_B_OE(INT_B_OE),
   .SDA_O(SDA_O), .RESET_PIN_O(RESET_PIN_O), .RESET_PIN_OE(RESET_PIN_OE),
   .CASE_OPEN_SENSE_O(CASE_OPEN_SENSE_O), .CASE_OPEN_SENSE_OE(CASE_OPEN_SENSE_OE),
   .TREE_TEST_SEL_DAC_OUT(TREE_TEST_SEL_DAC_OUT),
   .ADDR_LOW_STRAP_TREE_OUT_OE(ADDR_LOW_STRAP_TREE_OUT_OE), .DAC_EN(DAC_EN));
`default_nettype wire

// >>> test/mpc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module mpc_host_model (
   output var  logic lclk,
   output wire logic sda,
   input  wire logic dev_pull
);
   logic host_low = 1'b0;
   // pulled-up line, either side may only pull low
   assign sda = !(host_low || dev_pull);
   initial lclk = 1'b0;
   // clock runs only inside a frame, msb first
   task automatic frame(input logic [7:0] b, input logic drive);
      for (int i = 7; i >= 0; i--) begin
         host_low = drive && !b[i];
         #80 lclk = 1'b1;
         #80 lclk = 1'b0;
      end
      host_low = 1'b0;
   endtask : frame
endmodule : mpc_host_model
`default_nettype wire

// >>> test/mpc_pin_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module mpc_pin_ctrl_tb
   import mpc_pkg::*;
;
   localparam int PL = 20;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, v;
   logic        lclk, sda_o, sda_oe, a0_o, a0_oe, a0_strap, a1, cs_o, cs_oe, latch;
   logic        tsel, dac_en, irq, int_o, int_oe, rp_o, rp_oe, ext_low;
   logic [7:0]  dac_code;
   logic [1:0]  sal;
   wire logic   sda;
   int          err_count, n_compared;
   mpc_pin_ctrl #(.PULSE_LEN(PL)) i_mpc_pin_ctrl (
      .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .LINK_CLK(lclk), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
      .ADDR_LOW_STRAP_TREE_OUT_I(a0_oe ? a0_o : a0_strap),
      .ADDR_LOW_STRAP_TREE_OUT_O(a0_o), .ADDR_LOW_STRAP_TREE_OUT_OE(a0_oe),
      .ADDR_HIGH_STRAP(a1), .CASE_OPEN_SENSE_I(latch && !cs_oe),
      .CASE_OPEN_SENSE_O(cs_o), .CASE_OPEN_SENSE_OE(cs_oe),
      .TREE_TEST_SEL_DAC_OUT(tsel), .DAC_CODE(dac_code), .DAC_EN(dac_en),
      .IRQ_REQ(irq), .INT_B_O(int_o), .INT_B_OE(int_oe),
      .RESET_PIN_I(!(rp_oe || ext_low)), .RESET_PIN_O(rp_o), .RESET_PIN_OE(rp_oe),
      .SLAVE_ADDR_LOW(sal));
   mpc_host_model i_mpc_host_model (.lclk(lclk), .sda(sda), .dev_pull(sda_oe));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // external intrusion latch clears while the line is pulled low
   always @(posedge clk) if (cs_oe === 1'b1) latch <= 1'b0;
   // ****************************************
   // helpers
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      v = prdata;
      e = pslverr;
      if (n >= 50) err_count++;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, idx, 32'h0);
      chk(v & m, x);
   endtask : rd_chk
   task automatic pulse(input logic cs, input logic [7:0] idx, input logic [31:0] d);
      int hi;
      hi = 0;
      apb(1'b1, idx, d);
      repeat (3 * PL) begin
         @(posedge clk);
         if ((cs ? cs_oe : rp_oe) === 1'b1) hi++;
      end
      chk(hi, PL);
   endtask : pulse
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      cyc(2);
      chk(sal, 2'h2);
      chk(dac_en, 1'b1);
      chk(int_oe, 1'b0);
      rd_chk(IDX_CONFIG, 32'hff, CFG_RST);
      rd_chk(IDX_DAC, 32'hff, DAC_RST);
      apb(1'b0, 8'h41, 32'h0);
      chk(e, 1'b1);
      $display("reset test done");
   endtask : t_reset
   task automatic t_irq;
      apb(1'b1, IDX_CONFIG, 32'h02);
      cyc(2);
      chk(int_oe, 1'b1);
      irq <= 1'b0;
      cyc(2);
      chk(int_oe, 1'b0);
      irq <= 1'b1;
      $display("irq test done");
   endtask : t_irq
   task automatic t_rst;
      apb(1'b1, IDX_CONFIG, 32'h12);
      cyc(4);
      chk(rp_oe, 1'b0);
      rd_chk(IDX_CONFIG, 32'hff, 32'h02);
      apb(1'b1, IDX_RST_CTRL, 32'h80);
      pulse(1'b0, IDX_CONFIG, 32'h12);
      rd_chk(IDX_CONFIG, 32'hff, 32'h02);
      rd_chk(IDX_RST_CTRL, 32'hff, 32'h80);
      $display("reset pulse test done");
   endtask : t_rst
   task automatic t_case;
      latch <= 1'b1;
      cyc(4);
      rd_chk(IDX_STATUS, 32'h1, 32'h1);
      pulse(1'b1, IDX_CONFIG, 32'h42);
      rd_chk(IDX_STATUS, 32'h1, 32'h0);
      latch <= 1'b1;
      pulse(1'b1, IDX_CASE_CLR, 32'h80);
      rd_chk(IDX_CASE_CLR, 32'hff, 32'h0);
      rd_chk(IDX_CONFIG, 32'hff, 32'h02);
      $display("case clear test done");
   endtask : t_case
   task automatic t_ext;
      apb(1'b1, IDX_DAC, 32'h3c);
      cyc(2);
      chk(dac_code, 8'h3c);
      ext_low <= 1'b1;
      cyc(6);
      ext_low <= 1'b0;
      cyc(6);
      rd_chk(IDX_DAC, 32'hff, DAC_RST);
      rd_chk(IDX_CONFIG, 32'hff, CFG_RST);
      $display("external reset test done");
   endtask : t_ext
   task automatic t_tree;
      tsel <= 1'b1;
      cyc(6);
      chk(a0_oe, 1'b1);
      chk(a0_o, 1'b1);
      chk(dac_en, 1'b0);
      rd_chk(IDX_STATUS, 32'h8, 32'h8);
      tsel <= 1'b0;
      cyc(6);
      chk(a0_oe, 1'b0);
      chk(dac_en, 1'b1);
      $display("tree test done");
   endtask : t_tree
   task automatic t_link;
      apb(1'b1, IDX_LINK, 32'h1);
      i_mpc_host_model.frame(8'hff, 1'b0);
      chk(sda, 1'b0);
      apb(1'b1, IDX_LINK, 32'h0);
      i_mpc_host_model.frame(8'hff, 1'b0);
      chk(sda, 1'b1);
      i_mpc_host_model.frame(8'h55, 1'b1);
      i_mpc_host_model.frame(8'h55, 1'b1);
      cyc(10);
      rd_chk(IDX_STATUS, 32'hff00, 32'h5500);
      $display("link test done");
   endtask : t_link
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #500000;
      err_count++;
      tally_and_finish;
   end
   initial begin
      err_count = 0;
      n_compared = 0;
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      {a0_strap, a1, latch, tsel, irq, ext_low} = 6'b010010;
      fork
         cyc(4);
         i_mpc_host_model.frame(8'h00, 1'b0);
      join
      @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_irq;
      t_rst;
      t_case;
      t_ext;
      t_tree;
      t_link;
      tally_and_finish;
   end
endmodule : mpc_pin_ctrl_tb
`default_nettype wire
